// ---- aps_host_model.sv ----
// host processor model: strobed byte writes and reads on the register port
// assumes the bench calls its tasks; pins move only on falling edges
`timescale 1ns/1ps
module aps_host_model (
   input wire logic i_clk,
   output logic o_cs_n = 1'b1,
   output logic o_wr_n = 1'b1,
   output logic o_rd_n = 1'b1,
   output logic [7:0] o_addr = 8'h00,
   output logic [7:0] o_data = 8'h00
);
   // strobes and address held well past the two-flop sync
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_cs_n = 1'b0;
      o_wr_n = 1'b0;
      o_addr = a;
      o_data = d;
      repeat (4) @(negedge i_clk);
      o_wr_n = 1'b1;
      repeat (4) @(negedge i_clk);
      o_cs_n = 1'b1;
      o_data = ~d; // released bus shows no stale byte
      repeat (3) @(negedge i_clk);
   endtask
   // read strobe spans the answer latency with margin
   task automatic rd(input logic [7:0] a);
      @(negedge i_clk);
      o_cs_n = 1'b0;
      o_rd_n = 1'b0;
      o_addr = a;
      repeat (6) @(negedge i_clk);
      o_rd_n = 1'b1;
      repeat (4) @(negedge i_clk);
      o_cs_n = 1'b1;
      repeat (3) @(negedge i_clk);
   endtask
endmodule // aps_host_model

// ---- aps_pkg.sv ----
// constants for the arbitrary pulse segment register bank
// assumes an 8-bit host address with channel in bits 6..4 and index in 3..0
package aps_pkg;
   localparam int NUM_CHAN = 8;
   localparam int NUM_SEG = 8;
   localparam int NUM_LOCAL = 3;
   localparam int AMP_W = 7;
   localparam int MAG_W = 6;
   localparam int SIGN_BIT = 6;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int CHAN_LSB = 4;
   localparam int CHAN_W = 3;
   localparam int IDX_W = 4;
   localparam int PAGE_BIT = 7;
   localparam logic [3:0] IDX_SEG_FOUR = 4'hb;
   localparam logic [3:0] IDX_SEG_FIVE = 4'hc;
   localparam logic [3:0] IDX_SEG_SIX = 4'hd;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic [2:0] SLOT_SEG_FOUR = 3'h3;
   localparam logic [2:0] SLOT_SEG_FIVE = 3'h4;
   localparam logic [2:0] SLOT_SEG_SIX = 3'h5;
   localparam int CLK_PERIOD_NS = 25;
   localparam int MCLK_PERIOD_NS = 648;
   localparam int NUM_OTHER = 5;

   // local register index to 0..2, or 3 when unmapped
   function automatic logic [1:0] aps_local_slot(input logic [3:0] idx);
      logic [1:0] s;
      s = 2'h3;
      if (idx == IDX_SEG_FOUR) s = 2'h0;
      if (idx == IDX_SEG_FIVE) s = 2'h1;
      if (idx == IDX_SEG_SIX) s = 2'h2;
      return s;
   endfunction
endpackage

// ---- aps_pulse_seq.sv ----
// one channel's arbitrary pulse sequencer: plays eight segments in order
// assumes mark is a one-cycle request on the same clock
`timescale 1ns/1ps
module aps_pulse_seq #(
   parameter int SEG_CYCLES = 3
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   aps_seg_if.gen seg,
   output logic o_active,
   output logic o_sign,
   output logic [aps_pkg::MAG_W-1:0] o_magnitude
);
   typedef enum logic [0:0] {aps_idle = 1'b0, aps_play = 1'b1} aps_state_type;
   aps_state_type state;
   logic [2:0] slot;
   logic [15:0] cyc;
   logic last_cyc;
   logic [aps_pkg::AMP_W-1:0] cur;

   // the cycle counter is sixteen bits wide
   if (SEG_CYCLES < 1 || SEG_CYCLES > 65535) begin : g_bad_cycles
      $error("SEG_CYCLES out of range");
   end

   assign last_cyc = (cyc == 16'(SEG_CYCLES - 1));
   assign cur = seg.seg_amp[slot];

   // segments advance in ascending order, eight of them fit within one period
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= aps_idle;
         slot <= 3'h0;
         cyc <= 16'h0000;
      end else begin
         unique case (state)
            aps_idle: begin
               cyc <= 16'h0000;
               slot <= 3'h0;
               if (seg.mark && seg.arb_mode) state <= aps_play;
            end
            aps_play: begin
               if (last_cyc) begin
                  cyc <= 16'h0000;
                  slot <= slot + 3'h1;
                  if (slot == 3'(aps_pkg::NUM_SEG - 1)) state <= aps_idle;
               end else begin
                  cyc <= cyc + 16'h0001;
               end
            end
         endcase
      end
   end

   // drive each segment at its own amplitude, sign bit apart
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_active <= 1'b0;
         o_sign <= 1'b0;
         o_magnitude <= '0;
      end else if (state == aps_play) begin
         o_active <= 1'b1;
         o_sign <= cur[aps_pkg::SIGN_BIT];
         o_magnitude <= cur[aps_pkg::MAG_W-1:0];
      end else begin
         o_active <= 1'b0;
         o_sign <= 1'b0;
         o_magnitude <= '0;
      end
   end
endmodule // aps_pulse_seq

// ---- aps_seg_if.sv ----
// carrier between the register bank and one channel's pulse sequencer
// assumes one instance per channel
`timescale 1ns/1ps
interface aps_seg_if;
   logic [aps_pkg::NUM_SEG-1:0][aps_pkg::AMP_W-1:0] seg_amp;
   logic arb_mode;
   logic mark;
   modport bank (output seg_amp, output arb_mode, output mark);
   modport gen (input seg_amp, input arb_mode, input mark);
endinterface

// ---- aps_segment_regs.sv ----
// per-channel segment four..six amplitude registers and pulse playback
// assumes an asynchronous host strobe port; other segments arrive as inputs
//
// How it works
// - each channel plays its own waveform when its arbitrary mode is selected
// - a pulse is eight consecutive segments, rounded down to fit within one master clock period
// - each channel holds a 7-bit amplitude per segment, driven for that segment
// - amplitude is sign-magnitude, bit six the sign, bit zero least significant
// - segment-four register value is played in the fourth segment
// - segment-five value in the fifth segment, segment-six value in the sixth
// - address bits six to four pick the channel, low four bits the register
// - segment one plays first, segment eight last, the rest ascending
`timescale 1ns/1ps
module aps_segment_regs #(
   parameter int MCLK_PERIOD_NS = aps_pkg::MCLK_PERIOD_NS
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_cs_n,
   input wire logic i_wr_n,
   input wire logic i_rd_n,
   input wire logic [aps_pkg::ADDR_W-1:0] i_addr,
   input wire logic [aps_pkg::DATA_W-1:0] i_data,
   output logic [aps_pkg::DATA_W-1:0] o_data,
   output logic o_data_oe_n,
   input wire logic [aps_pkg::NUM_CHAN-1:0] i_arb_mode,
   input wire logic [aps_pkg::NUM_CHAN-1:0] i_tx_mark,
   input wire logic [aps_pkg::NUM_CHAN-1:0][aps_pkg::NUM_OTHER-1:0][aps_pkg::AMP_W-1:0]
      i_other_amp,
   output logic [aps_pkg::NUM_CHAN-1:0] o_tx_active,
   output logic [aps_pkg::NUM_CHAN-1:0] o_tx_sign,
   output logic [aps_pkg::NUM_CHAN-1:0][aps_pkg::MAG_W-1:0] o_tx_magnitude
);
   // segment length rounded down so eight never overrun one period
   localparam int SEG_NS = MCLK_PERIOD_NS / aps_pkg::NUM_SEG;
   localparam int SEG_RAW = SEG_NS / aps_pkg::CLK_PERIOD_NS;
   localparam int SEG_CYCLES = (SEG_RAW < 1) ? 1 : SEG_RAW;

   // refuse periods that eight whole segments cannot fill
   if (MCLK_PERIOD_NS < aps_pkg::NUM_SEG * aps_pkg::CLK_PERIOD_NS) begin : g_bad_short
      $error("MCLK_PERIOD_NS too short for eight segments");
   end
   // the sequencer counts segment cycles in sixteen bits
   if (SEG_CYCLES > 65535) begin : g_bad_long
      $error("MCLK_PERIOD_NS too long for the segment counter");
   end

   // host pins are asynchronous; stage one feeds stage two only
   logic cs_s1, cs_s2, cs_s3;
   logic wr_s1, wr_s2, wr_s3;
   logic rd_s1, rd_s2;
   logic [aps_pkg::ADDR_W-1:0] addr_s1, addr_s2;
   logic [aps_pkg::DATA_W-1:0] data_s1, data_s2;

   // chip select; the third stage lines it up with the write release
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
      end else begin
         cs_s1 <= i_cs_n;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
      end
   end

   // write strobe; the third stage exposes its rising edge
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_s1 <= 1'b1;
         wr_s2 <= 1'b1;
         wr_s3 <= 1'b1;
      end else begin
         wr_s1 <= i_wr_n;
         wr_s2 <= wr_s1;
         wr_s3 <= wr_s2;
      end
   end

   // read strobe, used as a level
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rd_s1 <= 1'b1;
         rd_s2 <= 1'b1;
      end else begin
         rd_s1 <= i_rd_n;
         rd_s2 <= rd_s1;
      end
   end

   // address; the host keeps it steady well past the strobe
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         addr_s1 <= '0;
         addr_s2 <= '0;
      end else begin
         addr_s1 <= i_addr;
         addr_s2 <= addr_s1;
      end
   end

   // write data; a torn sample is harmless since it is used only at release
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         data_s1 <= '0;
         data_s2 <= '0;
      end else begin
         data_s1 <= i_data;
         data_s2 <= data_s1;
      end
   end

   // address split: page bit must be clear, then channel and index
   logic [aps_pkg::CHAN_W-1:0] chan;
   logic [1:0] lslot;
   logic hit;
   logic wr_commit;
   logic rd_active;

   assign chan = addr_s2[aps_pkg::CHAN_LSB +: aps_pkg::CHAN_W];
   assign lslot = aps_pkg::aps_local_slot(addr_s2[aps_pkg::IDX_W-1:0]);
   assign hit = !addr_s2[aps_pkg::PAGE_BIT] && (lslot != 2'h3);
   // commit at strobe release so the data has settled on the pins
   assign wr_commit = wr_s2 && !wr_s3 && !cs_s3;
   assign rd_active = !rd_s2 && !cs_s2;

   // storage: channel by local slot, eight bits each including the spare top bit
   logic [aps_pkg::NUM_CHAN-1:0][aps_pkg::NUM_LOCAL-1:0][aps_pkg::DATA_W-1:0] store;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int c = 0; c < aps_pkg::NUM_CHAN; c++) begin
            for (int s = 0; s < aps_pkg::NUM_LOCAL; s++) begin
               store[c][s] <= aps_pkg::RESET_VALUE;
            end
         end
      end else if (wr_commit && hit) begin
         store[chan][lslot] <= data_s2;
      end
   end

   // read value picked ahead of the register; unmapped reads give zero
   logic [aps_pkg::DATA_W-1:0] next_rd_data;

   always_comb begin
      next_rd_data = aps_pkg::RESET_VALUE;
      if (rd_active && hit) next_rd_data = store[chan][lslot];
   end

   // bus drive follows the synced strobes, so it trails the pins by three edges
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) o_data_oe_n <= 1'b1;
      else o_data_oe_n <= !rd_active;
   end

   // read data register; zero whenever no read is under way
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) o_data <= aps_pkg::RESET_VALUE;
      else o_data <= next_rd_data;
   end

   // one sequencer per channel; the top bit never reaches the waveform
   for (genvar c = 0; c < aps_pkg::NUM_CHAN; c++) begin : g_chan
      aps_seg_if u_if ();

      assign u_if.arb_mode = i_arb_mode[c];
      assign u_if.mark = i_tx_mark[c];
      assign u_if.seg_amp[0] = i_other_amp[c][0];
      assign u_if.seg_amp[1] = i_other_amp[c][1];
      assign u_if.seg_amp[2] = i_other_amp[c][2];
      assign u_if.seg_amp[aps_pkg::SLOT_SEG_FOUR] =
         store[c][0][aps_pkg::AMP_W-1:0];
      assign u_if.seg_amp[aps_pkg::SLOT_SEG_FIVE] =
         store[c][1][aps_pkg::AMP_W-1:0];
      assign u_if.seg_amp[aps_pkg::SLOT_SEG_SIX] =
         store[c][2][aps_pkg::AMP_W-1:0];
      assign u_if.seg_amp[6] = i_other_amp[c][3];
      assign u_if.seg_amp[7] = i_other_amp[c][4];

      aps_pulse_seq #(
         .SEG_CYCLES(SEG_CYCLES)
      ) u_seq (
         .i_clk(i_clk),
         .i_reset_n(i_reset_n),
         .seg(u_if.gen),
         .o_active(o_tx_active[c]),
         .o_sign(o_tx_sign[c]),
         .o_magnitude(o_tx_magnitude[c])
      );
   end
endmodule // aps_segment_regs

// ---- aps_segment_regs_chk.sv ----
// assertions on the host port and pulse outputs of the segment bank
// assumes binding to aps_segment_regs; channel zero stands for all
`timescale 1ns/1ps
module aps_segment_regs_chk #(
   parameter int MCLK_PERIOD_NS = aps_pkg::MCLK_PERIOD_NS
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] o_data,
   input wire logic o_data_oe_n,
   input wire logic [7:0] i_arb_mode,
   input wire logic [7:0] i_tx_mark,
   input wire logic [7:0][4:0][6:0] i_other_amp,
   input wire logic [7:0] o_tx_active,
   input wire logic [7:0] o_tx_sign,
   input wire logic [7:0][5:0] o_tx_magnitude
);
   localparam int SEG = (MCLK_PERIOD_NS / 8) / 25;
   logic [7:0] cnt;
   // cycles spent active so far in this pulse
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) cnt <= 8'h00;
      else cnt <= o_tx_active[0] ? cnt + 8'h01 : 8'h00;
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   sequence rd_held;
      (!i_cs_n && !i_rd_n)[*5];
   endsequence
   sequence rd_far;
      (!i_cs_n && !i_rd_n && i_addr[7])[*5];
   endsequence
   a_read_drive: assert property (rd_held |-> !o_data_oe_n) else $error("bus not driven");
   a_read_free: assert property (i_rd_n[*5] |-> o_data_oe_n) else $error("bus held");
   a_page_zero: assert property (rd_far |-> o_data == 8'h00) else $error("page hit");
   a_pulse_go: assert property (i_tx_mark[0] && i_arb_mode[0] && !o_tx_active[0]
      |-> ##2 o_tx_active[0]) else $error("pulse not started");
   a_mode_off: assert property (i_tx_mark[0] && !i_arb_mode[0] && !o_tx_active[0]
      |-> ##2 !o_tx_active[0]) else $error("pulse without mode");
   a_pulse_len: assert property ($fell(o_tx_active[0]) |-> cnt == 8 * SEG)
      else $error("pulse length");
   a_seg_first: assert property (o_tx_active[0] && cnt < SEG
      |-> {o_tx_sign[0], o_tx_magnitude[0]} == i_other_amp[0][0]) else $error("seg1");
   a_seg_last: assert property (o_tx_active[0] && cnt >= 7 * SEG
      |-> {o_tx_sign[0], o_tx_magnitude[0]} == i_other_amp[0][4]) else $error("seg8");
   a_idle_quiet: assert property (!o_tx_active[0]
      |-> !o_tx_sign[0] && o_tx_magnitude[0] == 6'h00) else $error("idle output");
endmodule // aps_segment_regs_chk
bind aps_segment_regs aps_segment_regs_chk #(.MCLK_PERIOD_NS(MCLK_PERIOD_NS)) i_chk (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_addr(i_addr),
   .o_data(o_data), .o_data_oe_n(o_data_oe_n), .i_arb_mode(i_arb_mode), .i_tx_mark(i_tx_mark),
   .i_other_amp(i_other_amp), .o_tx_active(o_tx_active), .o_tx_sign(o_tx_sign),
   .o_tx_magnitude(o_tx_magnitude));

// ---- aps_segment_regs_tb_top.sv ----
// testbench for the segment register bank: access, reset values, playback
// assumes the host model owns the register port, the bench the pulse side
`timescale 1ns/1ps
module aps_segment_regs_tb_top;
   localparam int SEG = (aps_pkg::MCLK_PERIOD_NS / 8) / 25;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic cs_n, wr_n, rd_n, o_data_oe_n, oe_q = 1'b1;
   logic [7:0] addr, wdata, o_data, act, sgn, arb = 8'h00, mark = 8'h00;
   logic [7:0][5:0] mag;
   logic [7:0][4:0][6:0] other = '0;
   logic [7:0] shadow [8][3];
   logic [7:0] exp_q [$];
   int n_errors = 0, num_checks = 0, seed = 25, ch = 0;
   aps_host_model i_host (.i_clk(i_clk), .o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n),
      .o_addr(addr), .o_data(wdata));
   aps_segment_regs i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cs_n(cs_n), .i_wr_n(wr_n),
      .i_rd_n(rd_n), .i_addr(addr), .i_data(wdata), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
      .i_arb_mode(arb), .i_tx_mark(mark), .i_other_amp(other), .o_tx_active(act),
      .o_tx_sign(sgn), .o_tx_magnitude(mag));
   initial forever #12.5 i_clk = ~i_clk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   function automatic logic [7:0] adr(input int c, input int k);
      return {1'b0, 3'(c), aps_pkg::IDX_SEG_FOUR + 4'(k)};
   endfunction
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_host.rd(a);
   endtask
   // whole segment table of one channel, then a mark that must be ignored
   task automatic pulse(input int c);
      logic [6:0] v;
      ch = c;
      for (int k = 0; k < 5; k++) other[c][k] = 7'($random(seed));
      for (int s = 0; s < 8; s++) begin
         v = s < 3 ? other[c][s] : s < 6 ? shadow[c][s-3][6:0] : other[c][s-3];
         repeat (SEG) exp_q.push_back({1'b0, v});
      end
      @(negedge i_clk);
      mark[c] = 1'b1;
      @(negedge i_clk);
      mark[c] = 1'b0;
      repeat (5) @(negedge i_clk);
      mark[c] = 1'b1; // busy channel drops this one
      @(negedge i_clk);
      mark[c] = 1'b0;
      repeat (8 * SEG + 4) @(negedge i_clk);
      chk(8'(exp_q.size()), 8'h00);
   endtask
   // oldest note against each read answer and each played cycle
   always @(negedge i_clk) begin
      if (o_data_oe_n === 1'b0 && oe_q === 1'b1) chk(o_data, exp_q.pop_front());
      if (act[ch] === 1'b1) chk({1'b0, sgn[ch], mag[ch]}, exp_q.pop_front());
      oe_q = o_data_oe_n;
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge i_clk);
      @(negedge i_clk);
      i_reset_n = 1'b1;
      for (int c = 0; c < 8; c++)
         for (int k = 0; k < 3; k++) rd_chk(adr(c, k), 8'h00);
      $display("test reset values done");
      for (int c = 0; c < 8; c++)
         for (int k = 0; k < 3; k++) begin
            shadow[c][k] = 8'($random(seed));
            i_host.wr(adr(c, k), shadow[c][k]);
         end
      i_host.wr(8'h8b, 8'h5a); // page bit set must not alias channel zero
      i_host.wr(8'h0e, 8'ha5);
      for (int c = 0; c < 8; c++)
         for (int k = 0; k < 3; k++) rd_chk(adr(c, k), shadow[c][k]);
      rd_chk(8'h8b, 8'h00);
      rd_chk(8'h7e, 8'h00);
      $display("test register access done");
      @(negedge i_clk);
      mark[0] = 1'b1; // mode off, nothing may play
      @(negedge i_clk);
      mark[0] = 1'b0;
      repeat (8) @(negedge i_clk);
      arb = 8'hff;
      for (int c = 0; c < 8; c++) pulse(c);
      $display("test pulse playback done");
      @(negedge i_clk);
      i_reset_n = 1'b0; // mid-run reset must clear the stored bytes, checked on segment six of every channel
      repeat (2) @(negedge i_clk);
      i_reset_n = 1'b1;
      for (int c = 0; c < 8; c++) rd_chk(adr(c, 2), 8'h00);
      $display("test mid-run reset done");
      finish_test();
   end
endmodule // aps_segment_regs_tb_top
